/* rtl/flash_pins_pkg.sv */
// constants and types shared by the serial flash pin front end
// assumes one 10 MHz core clock and a 32-bit AHB-Lite register port
package flash_pins_pkg;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RXDATA = 8'h08;
   localparam logic [7:0] OFS_TXDATA = 8'h0c;
   localparam logic [7:0] OFS_ADDR   = 8'h10;
   localparam logic [7:0] OFS_MAP    = 8'h14;
   localparam logic [7:0] OFS_OP     = 8'h18;

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int         ST_MODE3   = 0;
   localparam int         ST_BUSY    = 1;
   localparam int         ST_ABORTED = 2;
   localparam int         ST_IN_RST  = 3;
   localparam int         ST_HOLD    = 4;
   localparam int         ST_ARMED   = 5;
   localparam int         ST_IN_MAP  = 6;
   localparam int         ST_BITS    = 8;
   localparam int         MAP_SECTOR = 0;
   localparam int         MAP_BLK32  = 12;
   localparam int         MAP_BLK64  = 20;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] TX_RESET   = 8'hff;

   // ************************************************************
   // lane widths
   // ************************************************************
   localparam logic [1:0] LANES_SINGLE = 2'h0;
   localparam logic [1:0] LANES_DUAL   = 2'h1;
   localparam logic [1:0] LANES_QUAD   = 2'h2;
   localparam logic [3:0] BYTE_BITS    = 4'h8;

   // ************************************************************
   // timing: length of an internal write, program or erase
   // ************************************************************
   localparam int          CLK_MHZ      = 10;
   localparam int          OP_TIME_US   = 50;
   localparam int          OP_CYCLES    = OP_TIME_US * CLK_MHZ;
   localparam logic [15:0] OP_CYCLES_16 = 16'(OP_CYCLES);

   // ************************************************************
   // types
   // ************************************************************
   typedef struct packed {
      logic       tx_drive;
      logic       spare;
      logic [1:0] lane_mode;
      logic       quad_command_mode;
      logic       quad_enable_bit;
      logic       pin_function_select_bit;
      logic       dedicated_reset_disable;
   } ctrl_t;

   typedef struct packed {
      logic [10:0] sector;
      logic [7:0]  blk32;
      logic [6:0]  blk64;
      logic        in_map;
   } map_t;

endpackage

/* rtl/flash_addr_map.sv */
// splits a 24-bit byte address into sector and block numbers
// assumes an 8 Mbyte array of uniform 4 Kbyte sectors
`timescale 1ns/1ps
module flash_addr_map
   import flash_pins_pkg::*;
(
   input  wire logic [23:0] byte_addr,
   output map_t             map
);

   always_comb begin
      map.sector = byte_addr[22:12];
      map.blk32  = byte_addr[22:15];
      map.blk64  = byte_addr[22:16];
      map.in_map = ~byte_addr[23];
   end

endmodule

/* rtl/flash_pin_front.sv */
// serial flash pin front end: reset, hold, lane sharing, mode 0/3 framing
// assumes all pins synchronous to CORE_CLK, serial clock far below 10 MHz
`timescale 1ns/1ps

// What this block does
// - low dedicated reset holds device, outputs floated
// - reset during internal operation aborts it
// - function bit 0 set ignores dedicated reset
// - only clock modes 0 and 3 supported
// - capture on rising edge, drive on falling
// - shared pin reset if select bit and bit 0 set, else hold
// - dual uses lanes 0-1, quad lanes 0-3
// - uniform 4K sectors in 32K/64K blocks
// - quad enable makes shared pin lane 3 only
// - hold floats output, pauses, keeps sequence state
// - select high ignores input; first needs fall
module flash_pin_front
   import flash_pins_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        SCK,
   input  wire logic        CS_N,
   input  wire logic        RESET_N,
   input  wire logic [3:0]  LANE_I,
   output logic      [3:0]  LANE_O,
   output logic      [3:0]  LANE_OE
);

   // ************************************************************
   // bus slave
   // ************************************************************
   logic        dsel_q;
   logic        dwr_q;
   logic [7:0]  dofs_q;
   logic [31:0] rdata_q;
   logic        wr_en;
   logic        rd_take;
   ctrl_t       ctrl_q;
   logic [7:0]  tx_q;
   logic [7:0]  rx_q;
   logic [23:0] addr_q;
   logic        mode3_q;
   logic        busy_q;
   logic        aborted_q;
   logic        armed_q;
   logic [15:0] op_cnt_q;
   logic [3:0]  bit_cnt_q;
   logic [31:0] status;
   map_t        map;

   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign HRDATA    = rdata_q;
   assign wr_en     = dsel_q & dwr_q;
   assign rd_take   = HSEL & HTRANS[1] & ~HWRITE & HREADY;

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         dsel_q <= 1'b0;
         dwr_q  <= 1'b0;
         dofs_q <= 8'h00;
      end else if (HREADY) begin
         dsel_q <= HSEL & HTRANS[1];
         dwr_q  <= HWRITE;
         dofs_q <= HADDR[7:0];
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_take) begin
         unique case (HADDR[7:0])
            OFS_CTRL:   rdata_q <= {24'h00_0000, ctrl_q};
            OFS_STATUS: rdata_q <= status;
            OFS_RXDATA: rdata_q <= {24'h00_0000, rx_q};
            OFS_TXDATA: rdata_q <= {24'h00_0000, tx_q};
            OFS_ADDR:   rdata_q <= {8'h00, addr_q};
            OFS_MAP:    rdata_q <= {5'h00, map.blk64, map.blk32, 1'b0, map.sector};
            default:    rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ctrl_q <= ctrl_t'(CTRL_RESET);
      end else if (wr_en && dofs_q == OFS_CTRL) begin
         ctrl_q <= ctrl_t'(HWDATA[7:0]);
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         tx_q <= TX_RESET;
      end else if (wr_en && dofs_q == OFS_TXDATA) begin
         tx_q <= HWDATA[7:0];
      end
   end

   // ************************************************************
   // pin roles and reset sources
   // ************************************************************
   logic       quad_on;
   logic       shared_hold;
   logic       shared_rst;
   logic       in_rst;
   logic       hold_act;
   logic [1:0] lanes;

   assign quad_on     = ctrl_q.quad_enable_bit | (lanes == LANES_QUAD);
   assign shared_rst  = ~quad_on & ctrl_q.dedicated_reset_disable
                        & ctrl_q.pin_function_select_bit;
   assign shared_hold = ~quad_on & ~shared_rst;
   assign in_rst      = (~ctrl_q.dedicated_reset_disable & ~RESET_N)
                        | (shared_rst & ~LANE_I[3]);
   assign hold_act    = shared_hold & ~LANE_I[3] & ~CS_N;
   assign lanes       = ctrl_q.quad_command_mode ? LANES_QUAD : ctrl_q.lane_mode;

   assign status = {16'h0000, 4'h0, bit_cnt_q, 1'b0, map.in_map, armed_q, hold_act,
                    in_rst, aborted_q, busy_q, mode3_q};

   // ************************************************************
   // internal write/program/erase timer
   // ************************************************************
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         busy_q   <= 1'b0;
         op_cnt_q <= 16'h0000;
      end else if (in_rst) begin
         busy_q   <= 1'b0;
         op_cnt_q <= 16'h0000;
      end else if (wr_en && dofs_q == OFS_OP) begin
         busy_q   <= 1'b1;
         op_cnt_q <= OP_CYCLES_16;
      end else if (busy_q) begin
         op_cnt_q <= op_cnt_q - 16'h0001;
         busy_q   <= (op_cnt_q != 16'h0001);
      end
   end

   // sticky abort flag, cleared by writing 1; a new abort wins
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         aborted_q <= 1'b0;
      end else if (in_rst && busy_q) begin
         aborted_q <= 1'b1;
      end else if (wr_en && dofs_q == OFS_STATUS && HWDATA[ST_ABORTED]) begin
         aborted_q <= 1'b0;
      end
   end

   // ************************************************************
   // serial framing
   // ************************************************************
   logic       sck_q;
   logic       cs_n_q;
   logic       rise;
   logic       fall;
   logic       active;
   logic [3:0] step;
   logic [3:0] bit_cnt_d;
   logic       byte_done;
   logic [7:0] rx_sh_q;
   logic [7:0] rx_sh_d;
   logic [7:0] tx_sh_q;
   logic [3:0] out_q;
   logic [3:0] lane_mask;

   assign rise   = SCK & ~sck_q;
   assign fall   = ~SCK & sck_q;
   assign active = ~CS_N & armed_q & ~in_rst & ~hold_act;

   always_comb begin
      unique case (lanes)
         LANES_DUAL: begin
            step      = 4'h2;
            lane_mask = 4'b0011;
            rx_sh_d   = {rx_sh_q[5:0], LANE_I[1:0]};
         end
         LANES_QUAD: begin
            step      = 4'h4;
            lane_mask = 4'b1111;
            rx_sh_d   = {rx_sh_q[3:0], LANE_I[3:0]};
         end
         default: begin
            step      = 4'h1;
            lane_mask = 4'b0010;
            rx_sh_d   = {rx_sh_q[6:0], LANE_I[0]};
         end
      endcase
      bit_cnt_d = bit_cnt_q + step;
      byte_done = (bit_cnt_d == BYTE_BITS);
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         sck_q  <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sck_q  <= SCK;
         cs_n_q <= CS_N;
      end
   end

   // select must be seen high once after power-up
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         armed_q <= 1'b0;
      end else if (CS_N) begin
         armed_q <= 1'b1;
      end
   end

   // clock level at select fall tells mode 0 from mode 3
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         mode3_q <= 1'b0;
      end else if (cs_n_q && !CS_N) begin
         mode3_q <= SCK;
      end
   end

   // receive path; hold only freezes, select high or reset restarts
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         bit_cnt_q <= 4'h0;
         rx_sh_q   <= 8'h00;
         rx_q      <= 8'h00;
         addr_q    <= 24'h00_0000;
      end else if (CS_N || in_rst) begin
         bit_cnt_q <= 4'h0;
         rx_sh_q   <= 8'h00;
      end else if (active && rise) begin
         rx_sh_q   <= rx_sh_d;
         bit_cnt_q <= byte_done ? 4'h0 : bit_cnt_d;
         if (byte_done) begin
            rx_q   <= rx_sh_d;
            addr_q <= {addr_q[15:0], rx_sh_d};
         end
      end
   end

   // transmit path: load while select high or in reset, and at each byte end
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         tx_sh_q <= TX_RESET;
         out_q   <= 4'h0;
      end else if (CS_N || in_rst) begin
         tx_sh_q <= tx_q;
         out_q   <= 4'h0;
      end else if (active && rise && byte_done) begin
         tx_sh_q <= tx_q;
      end else if (active && fall) begin
         unique case (lanes)
            LANES_DUAL: begin
               out_q   <= {2'b00, tx_sh_q[7:6]};
               tx_sh_q <= {tx_sh_q[5:0], 2'b11};
            end
            LANES_QUAD: begin
               out_q   <= tx_sh_q[7:4];
               tx_sh_q <= {tx_sh_q[3:0], 4'hf};
            end
            default: begin
               out_q   <= {2'b00, tx_sh_q[7], 1'b0};
               tx_sh_q <= {tx_sh_q[6:0], 1'b1};
            end
         endcase
      end
   end

   assign LANE_O  = out_q;
   assign LANE_OE = (active && ctrl_q.tx_drive) ? lane_mask : 4'h0;

   // ************************************************************
   // address map
   // ************************************************************
   flash_addr_map u_map (
      .byte_addr (addr_q),
      .map       (map)
   );

endmodule

/* verif/flash_host_model.sv */
// serial host model: drives clock, select, reset and lanes
// assumes clk is the core clock; each clock level lasts 4 cycles
`timescale 1ns/1ps
module flash_host_model
(
   input  wire logic       clk,
   input  wire logic [3:0] lane_o,
   output logic            sck,
   output logic            cs_n,
   output logic            reset_n,
   output logic [3:0]      lane_i
);
   initial begin
      sck     = 1'b0;
      cs_n    = 1'b1;
      reset_n = 1'b1;
      lane_i  = 4'h9;
   end
   task automatic gap();
      repeat (4) @(posedge clk);
   endtask
   task automatic pins(input logic rn, input logic h, input logic c);
      @(posedge clk);
      reset_n   <= rn;
      lane_i[3] <= h;
      cs_n      <= c;
      gap();
   endtask
   task automatic xfer(input logic m3, input logic [23:0] d, input int nb,
                       output logic [7:0] got);
      got = 8'h0;
      @(posedge clk);
      sck <= m3;
      gap();
      cs_n <= 1'b0;
      gap();
      for (int i = nb * 8 - 1; i >= 0; i--) begin
         sck         <= 1'b0;
         lane_i[0]   <= d[i];
         lane_i[2:1] <= ~lane_i[2:1];
         gap();
         sck <= 1'b1;
         got = {got[6:0], lane_o[1]};
         gap();
      end
      sck <= m3;
      gap();
      cs_n <= 1'b1;
      gap();
   endtask
   // one byte over w lanes (2 or 4), msb group first
   task automatic wide(input logic m3, input logic [7:0] d, input int w,
                       output logic [7:0] got);
      got = 8'h0;
      @(posedge clk);
      sck <= m3;
      gap();
      cs_n <= 1'b0;
      gap();
      for (int i = 8 - w; i >= 0; i -= w) begin
         sck <= 1'b0;
         if (w == 2) begin
            lane_i[1:0] <= d[i +: 2];
         end else begin
            lane_i <= d[i +: 4];
         end
         gap();
         sck <= 1'b1;
         got = (w == 2) ? {got[5:0], lane_o[1:0]} : {got[3:0], lane_o};
         gap();
      end
      sck <= m3;
      gap();
      cs_n   <= 1'b1;
      lane_i <= 4'h9;
      gap();
   endtask
endmodule

/* verif/flash_pin_front_chk.sv */
// assertions on the flash pin front end ports
// assumes bind to flash_pin_front; CTRL shadowed from bus writes
`timescale 1ns/1ps
module flash_pin_front_chk
   import flash_pins_pkg::*;
(
   input wire logic        CORE_CLK,
   input wire logic        RST,
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic        SCK,
   input wire logic        CS_N,
   input wire logic        RESET_N,
   input wire logic [3:0]  LANE_I,
   input wire logic [3:0]  LANE_O,
   input wire logic [3:0]  LANE_OE
);
   ctrl_t ctrl_q;
   logic  cw_q;
   logic  rt;
   logic  nq;
   logic  shr;
   assign rt  = HSEL && HTRANS[1] && HREADY && !HWRITE;
   assign nq  = !ctrl_q.quad_enable_bit && !ctrl_q.quad_command_mode
                && ctrl_q.lane_mode != LANES_QUAD;
   assign shr = ctrl_q.dedicated_reset_disable && ctrl_q.pin_function_select_bit;
   // ************
   // ctrl shadow
   // ************
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         cw_q   <= 1'b0;
         ctrl_q <= ctrl_t'(CTRL_RESET);
      end else begin
         cw_q <= HSEL && HTRANS[1] && HREADY && HWRITE && HADDR[7:0] == OFS_CTRL;
         if (cw_q) ctrl_q <= ctrl_t'(HWDATA[7:0]);
      end
   end
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   sequence s_rd_far;
      rt && HADDR[7:0] > 8'h1b;
   endsequence
   property p_okay;
      HREADYOUT && !HRESP;
   endproperty
   a_okay: assert property (p_okay) else $error("bus answer not okay");
   property p_rd_hold;
      $changed(HRDATA) |-> $past(rt);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_far;
      s_rd_far |=> HRDATA == 32'h0;
   endproperty
   a_far: assert property (p_far) else $error("unmapped read not zero");
   property p_ded_rst;
      !RESET_N && !ctrl_q.dedicated_reset_disable |-> LANE_OE == 4'h0;
   endproperty
   a_ded_rst: assert property (p_ded_rst) else $error("drive in reset");
   property p_sh_rst;
      !LANE_I[3] && nq && shr |-> LANE_OE == 4'h0;
   endproperty
   a_sh_rst: assert property (p_sh_rst) else $error("drive in pin reset");
   property p_hold;
      !LANE_I[3] && !CS_N && nq && !shr |-> LANE_OE == 4'h0;
   endproperty
   a_hold: assert property (p_hold) else $error("drive in hold");
   property p_desel;
      CS_N |-> LANE_OE == 4'h0;
   endproperty
   a_desel: assert property (p_desel) else $error("drive deselected");
   property p_lanes;
      ctrl_q.lane_mode != LANES_QUAD && !ctrl_q.quad_command_mode |->
         LANE_OE[3:2] == 2'h0 && (ctrl_q.lane_mode == LANES_DUAL || !LANE_OE[0]);
   endproperty
   a_lanes: assert property (p_lanes) else $error("wrong lanes driven");
   property p_out_edge;
      $changed(LANE_O) && !CS_N && !$past(CS_N, 2) && RESET_N && LANE_I[3]
         |-> !$past(SCK);
   endproperty
   a_out_edge: assert property (p_out_edge) else $error("output off falling edge");
endmodule
bind flash_pin_front flash_pin_front_chk flash_pin_front_chk_i (
   .CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SCK(SCK), .CS_N(CS_N),
   .RESET_N(RESET_N), .LANE_I(LANE_I), .LANE_O(LANE_O), .LANE_OE(LANE_OE));

/* verif/test_flash_pin_front.sv */
// bench for the flash pin front end: bus master, host model, checks
// assumes host model and checker compiled before this file
`timescale 1ns/1ps
module test_flash_pin_front
   import flash_pins_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        sck, cs_n, reset_n;
   logic [3:0]  lane_h, lane_w, lane_o, lane_oe;
   int          n_errors = 0;
   int          compares = 0;
   logic [7:0]  seed = 8'h5d;
   always #50 clk = ~clk;
   assign lane_w = (lane_oe & lane_o) | (~lane_oe & lane_h);
   flash_pin_front flash_pin_front_i (
      .CORE_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .SCK(sck), .CS_N(cs_n),
      .RESET_N(reset_n), .LANE_I(lane_w), .LANE_O(lane_o), .LANE_OE(lane_oe));
   flash_host_model flash_host_model_i (
      .clk(clk), .lane_o(lane_w), .sck(sck), .cs_n(cs_n), .reset_n(reset_n),
      .lane_i(lane_h));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [31:0] map_of(input logic [23:0] a);
      return {5'h0, a[22:16], a[22:15], 1'b0, a[22:12]};
   endfunction
   // ************
   // bus tasks
   // ************
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e,
                      input string s);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      chk(v & k, e, s);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus(1'b1, a, d, v);
   endtask
   task automatic test_done();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      test_done();
   end
   initial begin
      logic [7:0]  tx, got;
      logic [23:0] a;
      logic [12:0] pt [5];
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rdc(OFS_CTRL, 32'hff, 32'h0, "ctrl reset");
      rdc(OFS_TXDATA, 32'hff, 32'hff, "tx reset");
      rdc(8'h1c, 32'hffffffff, 32'h0, "unmapped");
      wr(OFS_CTRL, 32'h80);
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         tx = seed;
         seed = lfsr(seed);
         wr(OFS_TXDATA, {24'h0, tx});
         flash_host_model_i.xfer(k[0], {16'h0, seed}, 1, got);
         rdc(OFS_RXDATA, 32'hff, {24'h0, seed}, "rx byte");
         rdc(OFS_STATUS, 32'h1, {31'h0, k[0]}, "mode");
         if (k[0]) chk({24'h0, got}, {24'h0, tx}, "tx byte");
      end
      // dual lanes out in mode 3, quad lanes in with lane 3 low in mode 0
      seed = lfsr(seed);
      tx = seed;
      wr(OFS_TXDATA, {24'h0, tx});
      wr(OFS_CTRL, 32'h90);
      flash_host_model_i.wide(1'b1, ~tx, 2, got);
      chk({24'h0, got}, {24'h0, tx}, "dual tx");
      wr(OFS_CTRL, 32'h20);
      flash_host_model_i.wide(1'b0, 8'h3c, 4, got);
      rdc(OFS_RXDATA, 32'hff, 32'h3c, "quad rx");
      wr(OFS_CTRL, 32'h80);
      for (int k = 0; k < 3; k++) begin
         seed = lfsr(seed);
         a = (k == 0) ? 24'h7fffff : (k == 1) ? 24'h800000 : {seed, lfsr(seed), ~seed};
         flash_host_model_i.xfer(1'b0, a, 3, got);
         rdc(OFS_ADDR, 32'hffffff, {8'h0, a}, "addr bytes");
         rdc(OFS_MAP, 32'h07fff7ff, map_of(a), "map");
         rdc(OFS_STATUS, 32'h40, {25'h0, !a[23], 6'h0}, "in map");
      end
      wr(OFS_CTRL, 32'h0);
      wr(OFS_OP, 32'h1);
      rdc(OFS_STATUS, 32'h6, 32'h2, "busy");
      flash_host_model_i.pins(1'b0, 1'b1, 1'b1);
      rdc(OFS_STATUS, 32'h8, 32'h8, "in reset");
      flash_host_model_i.pins(1'b1, 1'b1, 1'b1);
      rdc(OFS_STATUS, 32'h6, 32'h4, "aborted");
      wr(OFS_STATUS, 32'h4);
      rdc(OFS_STATUS, 32'h4, 32'h0, "abort clear");
      // ctrl, reset pin, shared pin, select, expected reset, expected hold
      pt = '{{8'h01, 5'h0c}, {8'h03, 5'h16}, {8'h07, 5'h14}, {8'h80, 5'h11}, {8'h01, 5'h11}};
      foreach (pt[i]) begin
         wr(OFS_CTRL, {24'h0, pt[i][12:5]});
         flash_host_model_i.pins(pt[i][4], pt[i][3], pt[i][2]);
         rdc(OFS_STATUS, 32'h18, {27'h0, pt[i][0], pt[i][1], 3'h0}, "role");
         flash_host_model_i.pins(1'b1, 1'b1, 1'b1);
      end
      test_done();
   end
endmodule
